// ==== sdc_pkg.sv ====
// Shared constants for the synthesizer control latches: latch select codes, field positions, timing.
// Assumes both ends and the bench compile it first.
package sdc_pkg;
    localparam int SDC_WORD_W = 24;
    localparam int SDC_SEL_W = 2;
    localparam logic [1:0] SDC_SEL_IF_REF = 2'h0;
    localparam logic [1:0] SDC_SEL_IF_DIV = 2'h1;
    localparam logic [1:0] SDC_SEL_RF_REF = 2'h2;
    localparam logic [1:0] SDC_SEL_RF_DIV = 2'h3;
    // Reference latch fields
    localparam int SDC_RR_CAL = 23;
    localparam int SDC_RR_DBL = 22;
    localparam int SDC_RR_STEP_HI = 21;
    localparam int SDC_RR_STEP_LO = 18;
    localparam int SDC_RR_POL = 17;
    localparam int SDC_IR_GAIN8 = 18;
    // IF divider latch fields
    localparam int SDC_IN_CLR = 23;
    localparam int SDC_IN_SLEEP = 22;
    localparam int SDC_IN_TIMING = 21;
    localparam int SDC_IN_FAST = 20;
    localparam int SDC_IN_TEST = 19;
    localparam int SDC_IN_OUT1 = 18;
    localparam int SDC_IN_OUT0 = 17;
    localparam int SDC_IN_MAIN_HI = 16;
    localparam int SDC_IN_MAIN_LO = 5;
    localparam int SDC_IN_SWAL_HI = 4;
    localparam int SDC_IN_SWAL_LO = 2;
    // RF divider latch fields
    localparam int SDC_RN_CLR = 23;
    localparam int SDC_RN_SLEEP = 22;
    localparam int SDC_RN_RANGE = 21;
    localparam int SDC_RN_C_HI = 20;
    localparam int SDC_RN_C_LO = 10;
    localparam int SDC_RN_B_HI = 9;
    localparam int SDC_RN_B_LO = 8;
    localparam int SDC_RN_A_HI = 7;
    localparam int SDC_RN_A_LO = 6;
    localparam int SDC_RN_F_HI = 5;
    localparam int SDC_RN_F_LO = 2;
    // Pump current
    localparam int SDC_PUMP_STEP_UA = 100;
    localparam logic [10:0] SDC_PUMP_STEP = 11'h064;
    // Host serial clock divider: last count of the half period, which lasts 6 sys cycles
    localparam logic [3:0] SDC_HALF_DIV = 4'h5;
    localparam logic [4:0] SDC_BITS_LAST = 5'h17;
    // Defaults
    localparam logic [23:0] SDC_WORD_RST = 24'h000000;
    // APB map of the host's own registers
    localparam logic [7:0] SDC_A_DATA = 8'h00;
    localparam logic [7:0] SDC_A_CTRL = 8'h04;
    localparam logic [7:0] SDC_A_STAT = 8'h08;
    typedef enum logic [1:0] {
        SDC_H_IDLE = 2'b00,
        SDC_H_SHIFT = 2'b01,
        SDC_H_LOAD = 2'b10,
        SDC_H_DONE = 2'b11
    } sdc_hstate_t;
endpackage : sdc_pkg

// ==== sdc_if.sv ====
// Three-wire programming link between host controller and synthesizer end.
// Assumes the bench instantiates it and hooks both modports.
`timescale 1ns/1ps
interface sdc_if;
    logic ser_clk;
    logic ser_data;
    logic load_strobe;
    modport host (output ser_clk, output ser_data, output load_strobe);
    modport device (input ser_clk, input ser_data, input load_strobe);
endinterface : sdc_if

// ==== sdc_device.sv ====
// Synthesizer end: serial shift register, latch commit and decoded control outputs.
// Assumes the link pins are asynchronous to clk_sys and far slower than it.
// Contract
// RL1: Reference bit 23 selects calibration speed
// RL2: Reference bit 22 enables pump supply doubler
// RL3: Reference bit 17 sets RF detector polarity
// RL4: Pump current equals step code plus one
// RL5: Select 01 commits to IF divider
// RL6: IF divider field layout as given
// RL7: Host keeps IF main count 3..4095
// RL8: IF swallow count plain 3-bit 0..7
// RL9: IF ratio 56..32767 continuous
// RL10: Bits 17,18 set general output levels
// RL11: IF bit 19 disables spur compensation
// RL12: Fast-settle: output 0 follows RF x8
// RL13: Fast-settle: output 1 follows IF x8
// RL14: Select 11 commits to RF divider
// RL15: RF divider field layout as given
// RL16: Host keeps coarse over mid/fine plus two
// RL17: Control bit 23 clears, 22 sleeps
// RL18: IF bit 21 picks sleep timing
// RL19: Synchronous sleep waits for pump pulse end
// RL20: RF bit 21 picks prescaler range
// RL21: MSB first, commit on strobe rise
// RL22: IF reference bit 18 pump gain
// RL23: Port works while loops sleep
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module sdc_device
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Link
    sdc_if.device link,
    // Pump pulse activity from the analog loops
    input wire logic rf_pump_busy,
    input wire logic if_pump_busy,
    // Reference latch fields
    output logic cal_fast,
    output logic pump_supply_doubler_on,
    output logic rf_detector_polarity,
    output logic [3:0] rf_pump_word,
    output logic [10:0] rf_pump_ua,
    output logic if_pump_gain_x8,
    // IF divider fields
    output logic if_counter_clear,
    output logic if_sleep,
    output logic sleep_timing_select,
    output logic frac_comp_off,
    output logic [11:0] if_main_count,
    output logic [2:0] if_swallow_count,
    output logic [14:0] if_ratio,
    // RF divider fields
    output logic rf_counter_clear,
    output logic rf_sleep,
    output logic rf_prescaler_range,
    output logic [10:0] rf_coarse_count,
    output logic [1:0] rf_mid_count,
    output logic [1:0] rf_fine_count,
    output logic [3:0] rf_fraction_numerator,
    // Effective power down
    output logic if_down,
    output logic rf_down,
    // General outputs, enable low while driving
    output logic gp_out0_o,
    output logic gp_out0_oe_n,
    output logic gp_out1_o,
    output logic gp_out1_oe_n
);
    import sdc_pkg::*;

    logic [1:0] clk_s_q, dat_s_q, le_s_q;
    logic clk_d1_q, le_d1_q;
    logic [23:0] shift_q;
    logic [23:0] if_ref_q, if_div_q, rf_ref_q, rf_div_q;
    logic if_down_q, rf_down_q;
    logic [10:0] pump_ua_q;

    // Synchronisers feed only their second stage
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clk_s_q <= 2'h0;
            dat_s_q <= 2'h0;
            le_s_q <= 2'h0;
            clk_d1_q <= 1'h0;
            le_d1_q <= 1'h0;
        end
        else if (clk_en)
        begin
            clk_s_q <= {clk_s_q[0], link.ser_clk};
            dat_s_q <= {dat_s_q[0], link.ser_data};
            le_s_q <= {le_s_q[0], link.load_strobe};
            clk_d1_q <= clk_s_q[1];
            le_d1_q <= le_s_q[1];
        end
    end

    wire clk_rise = clk_s_q[1] & ~clk_d1_q;
    wire le_rise = le_s_q[1] & ~le_d1_q;
    wire [1:0] sel = shift_q[1:0];

    // Shifting and committing never look at the sleep state [RL23]
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_q <= SDC_WORD_RST;
            if_ref_q <= SDC_WORD_RST;
            if_div_q <= SDC_WORD_RST;
            rf_ref_q <= SDC_WORD_RST;
            rf_div_q <= SDC_WORD_RST;
        end
        else if (clk_en)
        begin
            if (clk_rise)
                shift_q <= {shift_q[22:0], dat_s_q[1]}; // [RL21]
            if (le_rise)
            begin
                case (sel)
                    SDC_SEL_IF_REF: if_ref_q <= shift_q;
                    SDC_SEL_IF_DIV: if_div_q <= shift_q; // [RL5]
                    SDC_SEL_RF_REF: rf_ref_q <= shift_q;
                    SDC_SEL_RF_DIV: rf_div_q <= shift_q; // [RL14]
                    default: if_ref_q <= if_ref_q;
                endcase
            end
        end
    end

    assign cal_fast = rf_ref_q[SDC_RR_CAL]; // [RL1]
    assign pump_supply_doubler_on = rf_ref_q[SDC_RR_DBL]; // [RL2]
    assign rf_detector_polarity = rf_ref_q[SDC_RR_POL]; // [RL3]
    assign rf_pump_word = rf_ref_q[SDC_RR_STEP_HI:SDC_RR_STEP_LO];
    // Current in uA is (k+1) steps of 100; held in a flop so the pin never shows product glitches
    wire [10:0] pump_ua_d = 11'({7'h00, rf_pump_word} + 11'h001) * SDC_PUMP_STEP; // [RL4]
    assign rf_pump_ua = pump_ua_q;
    assign if_pump_gain_x8 = if_ref_q[SDC_IR_GAIN8]; // [RL22]

    assign if_counter_clear = if_div_q[SDC_IN_CLR]; // [RL17]
    assign if_sleep = if_div_q[SDC_IN_SLEEP]; // [RL17]
    assign sleep_timing_select = if_div_q[SDC_IN_TIMING]; // [RL18]
    assign frac_comp_off = if_div_q[SDC_IN_TEST]; // [RL11]
    assign if_main_count = if_div_q[SDC_IN_MAIN_HI:SDC_IN_MAIN_LO]; // [RL6]
    assign if_swallow_count = if_div_q[SDC_IN_SWAL_HI:SDC_IN_SWAL_LO]; // [RL8]
    // Prescaler of 8: N = 8*B + A; no check, host keeps B legal
    assign if_ratio = {if_main_count, if_swallow_count}; // [RL9]

    assign rf_counter_clear = rf_div_q[SDC_RN_CLR]; // [RL17]
    assign rf_sleep = rf_div_q[SDC_RN_SLEEP]; // [RL17]
    assign rf_prescaler_range = rf_div_q[SDC_RN_RANGE]; // [RL20]
    assign rf_coarse_count = rf_div_q[SDC_RN_C_HI:SDC_RN_C_LO]; // [RL15]
    assign rf_mid_count = rf_div_q[SDC_RN_B_HI:SDC_RN_B_LO];
    assign rf_fine_count = rf_div_q[SDC_RN_A_HI:SDC_RN_A_LO];
    assign rf_fraction_numerator = rf_div_q[SDC_RN_F_HI:SDC_RN_F_LO];

    // Synchronous mode defers entry until the pump pulse is over; wake is immediate
    wire if_go = if_sleep & (~sleep_timing_select | ~if_pump_busy); // [RL19]
    wire rf_go = rf_sleep & (~sleep_timing_select | ~rf_pump_busy); // [RL19]
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            if_down_q <= 1'h0;
            rf_down_q <= 1'h0;
            pump_ua_q <= SDC_PUMP_STEP;
        end
        else if (clk_en)
        begin
            pump_ua_q <= pump_ua_d; // [RL4]
            if_down_q <= if_sleep & (if_down_q | if_go); // [RL18]
            rf_down_q <= rf_sleep & (rf_down_q | rf_go);
        end
    end
    assign if_down = if_down_q;
    assign rf_down = rf_down_q;

    // General outputs: static levels or fast-settle open-drain
    wire fast = if_div_q[SDC_IN_FAST];
    assign gp_out0_o = fast ? 1'b0 : if_div_q[SDC_IN_OUT0]; // [RL10]
    assign gp_out1_o = fast ? 1'b0 : if_div_q[SDC_IN_OUT1]; // [RL10]
    assign gp_out0_oe_n = fast ? ~rf_ref_q[SDC_RR_STEP_HI] : 1'b0; // [RL12]
    assign gp_out1_oe_n = fast ? ~if_pump_gain_x8 : 1'b0; // [RL13]
endmodule : sdc_device

// ==== sdc_host.sv ====
// Host end: APB slave with a data word register; writing CTRL.go sends it over the link.
// Assumes an APB master on clk_sys; the link clock is made here by a divider.
`timescale 1ns/1ps
module sdc_host
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    sdc_if.host link
);
    import sdc_pkg::*;

    sdc_hstate_t st_q, st_d;
    logic [23:0] data_q, sh_q;
    logic [3:0] div_q;
    logic [4:0] bit_q;
    logic sclk_q, le_q, done_q;

    wire acc = psel & penable;
    wire wr_data = acc & pwrite & (paddr == SDC_A_DATA);
    wire wr_go = acc & pwrite & (paddr == SDC_A_CTRL) & pwdata[0];
    wire hit = (paddr == SDC_A_DATA) | (paddr == SDC_A_CTRL) | (paddr == SDC_A_STAT);
    wire busy = (st_q != SDC_H_IDLE);
    wire tick = (div_q == SDC_HALF_DIV);
    // Word written with go while busy is dropped; software polls STAT.busy
    wire start = wr_go & ~busy;

    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata = (paddr == SDC_A_DATA) ? {8'h00, data_q} :
                    (paddr == SDC_A_STAT) ? {30'h0, done_q, busy} : 32'h0;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            SDC_H_IDLE: if (start) st_d = SDC_H_SHIFT;
            SDC_H_SHIFT: if (tick & sclk_q & (bit_q == SDC_BITS_LAST)) st_d = SDC_H_LOAD;
            SDC_H_LOAD: if (tick & le_q) st_d = SDC_H_DONE;
            SDC_H_DONE: if (tick) st_d = SDC_H_IDLE;
            default: st_d = SDC_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q <= SDC_H_IDLE;
            data_q <= SDC_WORD_RST;
            sh_q <= SDC_WORD_RST;
            div_q <= 4'h0;
            bit_q <= 5'h00;
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            if (wr_data)
                data_q <= pwdata[23:0];
            div_q <= (tick | ~busy) ? 4'h0 : div_q + 4'h1;
            if (start)
            begin
                sh_q <= data_q;
                bit_q <= 5'h00;
                done_q <= 1'b0;
            end
            else if (tick)
            begin
                case (st_q)
                    SDC_H_SHIFT:
                    begin
                        sclk_q <= ~sclk_q;
                        // Data moves in the same cycle as the falling edge, MSB first [RL21]
                        if (sclk_q)
                        begin
                            sh_q <= {sh_q[22:0], 1'b0};
                            bit_q <= bit_q + 5'h01;
                        end
                    end
                    SDC_H_LOAD: le_q <= ~le_q; // [RL21]
                    SDC_H_DONE: done_q <= 1'b1;
                    default: sclk_q <= 1'b0;
                endcase
            end
        end
    end

    assign link.ser_clk = sclk_q;
    assign link.ser_data = sh_q[23];
    assign link.load_strobe = le_q;
endmodule : sdc_host

// ==== sdc_properties.sv ====
// Checker for the framing that the host end puts on the three-wire link.
// Assumes it is instantiated beside the link and sees clk_sys and sys_rst.
`timescale 1ns/1ps
module sdc_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_strobe
);
    logic sc_q;
    logic [4:0] pulses_q;
    // Count clock pulses of one frame; the strobe starts the next frame
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sc_q <= 1'b0;
            pulses_q <= 5'h00;
        end
        else
        begin
            sc_q <= ser_clk;
            if (load_strobe)
                pulses_q <= 5'h00;
            else if (ser_clk && !sc_q)
                pulses_q <= pulses_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence high_run;
        ser_clk [*6] ##1 !ser_clk;
    endsequence
    sequence low_run;
        !ser_clk [*6];
    endsequence
    clk_high_len_a: assert property ($rose(ser_clk) |-> high_run) else $error("clock high time wrong");
    clk_low_len_a: assert property ($fell(ser_clk) |-> low_run) else $error("clock low time wrong");
    data_hold_a: assert property (ser_clk && sc_q |-> $stable(ser_data)) else $error("data moved");
    strobe_clk_low_a: assert property (load_strobe |-> !ser_clk) else $error("clock under strobe");
    strobe_len_a: assert property ($rose(load_strobe) |-> load_strobe [*6] ##1 !load_strobe)
        else $error("strobe width wrong");
    strobe_gap_a: assert property ($fell(load_strobe) |-> low_run) else $error("clock too soon");
    bit_count_a: assert property ($rose(load_strobe) |-> pulses_q == 5'h18) else $error("not 24 bits");
    reset_idle_a: assert property ($fell(sys_rst) |-> !ser_clk && !load_strobe) else $error("pins busy");
    frame_c: cover property ($rose(load_strobe));
endmodule : sdc_properties

// ==== testbench.sv ====
// Testbench: APB drives the host end, which programs the synthesizer end over the link.
// Assumes sdc_pkg, sdc_if and both design ends are compiled first.
`timescale 1ns/1ps
module testbench;
    import sdc_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic busy = 1'b0;
    logic run = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, seed;
    logic pready, pslverr, e, sc_q, cal, dbl, pol, g8, ic, is, st, fo, rc, rs, rp, idn, rdn, g0, g0e, g1, g1e;
    logic [3:0] k, fr;
    logic [10:0] ua, cc;
    logic [11:0] im;
    logic [2:0] isw;
    logic [14:0] irt;
    logic [1:0] mc, fc;
    logic [23:0] w, cap, rr, ir, in_q, rn;
    logic [23:0] corner [7] = '{24'h3C0002, 24'h040000, 24'h110001, 24'h000000, 24'h0000E1, 24'h1FFFFD, 24'h900003};
    int fails = 0;
    int compares = 0;
    wire [80:0] act = {cal, dbl, pol, k, ua, g8, ic, is, st, fo, im, isw, irt, rc, rs, rp, cc, mc, fc, fr,
        idn, rdn, g0, g0e, g1, g1e};
    sdc_if i_sdc_if ();
    sdc_host i_sdc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(run), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(i_sdc_if.host));
    sdc_device i_sdc_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(run), .link(i_sdc_if.device),
        .rf_pump_busy(busy), .if_pump_busy(busy), .cal_fast(cal), .pump_supply_doubler_on(dbl),
        .rf_detector_polarity(pol), .rf_pump_word(k), .rf_pump_ua(ua), .if_pump_gain_x8(g8),
        .if_counter_clear(ic), .if_sleep(is), .sleep_timing_select(st), .frac_comp_off(fo), .if_main_count(im),
        .if_swallow_count(isw), .if_ratio(irt), .rf_counter_clear(rc), .rf_sleep(rs), .rf_prescaler_range(rp),
        .rf_coarse_count(cc), .rf_mid_count(mc), .rf_fine_count(fc), .rf_fraction_numerator(fr),
        .if_down(idn), .rf_down(rdn), .gp_out0_o(g0), .gp_out0_oe_n(g0e), .gp_out1_o(g1), .gp_out1_oe_n(g1e));
    sdc_properties i_sdc_properties (.clk_sys(clk_sys), .sys_rst(sys_rst), .ser_clk(i_sdc_if.ser_clk),
        .ser_data(i_sdc_if.ser_data), .load_strobe(i_sdc_if.load_strobe));
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Wire monitor: collects the bits at each serial clock rise
    always @(posedge clk_sys)
    begin
        sc_q <= i_sdc_if.ser_clk;
        if (i_sdc_if.ser_clk && !sc_q)
            cap <= {cap[22:0], i_sdc_if.ser_data};
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction : xs
    // Expected port levels from the shadow copies of the four latches
    function automatic logic [80:0] exp_out();
        logic f;
        logic d;
        f = in_q[20];
        d = !(in_q[21] && busy);
        exp_out = {rr[23], rr[22], rr[17], rr[21:18], 11'((int'(rr[21:18]) + 1) * SDC_PUMP_STEP_UA), ir[18],
            in_q[23:21], in_q[19], in_q[16:2], in_q[16:2], rn[23:2], in_q[22] && d, rn[22] && d,
            !f && in_q[17], f && !rr[21], !f && in_q[18], f && !ir[18]};
    endfunction : exp_out
    task summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    task chk(input logic ok, input string m);
        compares++;
        if (!ok)
        begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            chk(1'b0, "bus timeout");
            summarize();
        end
    endtask : apb
    task send(input logic [23:0] v);
        int n;
        apb(1'b1, SDC_A_DATA, {8'h00, v});
        apb(1'b1, SDC_A_CTRL, 32'h00000001);
        n = 0;
        do
        begin
            apb(1'b0, SDC_A_STAT, 32'h00000000);
            n++;
        end while (q[1] !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            chk(1'b0, "frame timeout");
            summarize();
        end
        repeat (8) @(posedge clk_sys);
        case (v[1:0])
            2'h0: ir = v;
            2'h1: in_q = v;
            2'h2: rr = v;
            default: rn = v;
        endcase
        chk(cap === v, "serial word");
        chk(act === exp_out(), "latched fields");
    endtask : send
    initial
    begin
        rr = 24'h0;
        ir = 24'h0;
        in_q = 24'h0;
        rn = 24'h0;
        seed = 32'h00000DEF;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk(act === exp_out(), "reset levels");
        apb(1'b0, 8'h0C, 32'h0);
        chk(e === 1'b1 && q === 32'h0, "unmapped access");
        apb(1'b1, SDC_A_DATA, 32'hFFFFFFFF);
        apb(1'b0, SDC_A_DATA, 32'h0);
        chk(q === 32'h00FFFFFF, "data readback");
        // A write while the enable is low must leave the data word untouched
        run <= 1'b0;
        apb(1'b1, SDC_A_DATA, 32'h00123456);
        run <= 1'b1;
        apb(1'b0, SDC_A_DATA, 32'h0);
        chk(q === 32'h00FFFFFF, "write while frozen");
        foreach (corner[i])
            send(corner[i]);
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            w = {seed[23:2], i[1:0]};
            // Keep the counts legal for the host side
            w[16] = w[16] || (i[1:0] == 2'h1);
            w[20] = w[20] || (i[1:0] == 2'h3);
            send(w);
        end
        send(24'h100003);
        send(24'h010001);
        busy <= 1'b1;
        send(24'h610001);
        busy <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(act === exp_out(), "sleep after pump pulse");
        send(24'h010001);
        busy <= 1'b1;
        send(24'h410001);
        busy <= 1'b0;
        summarize();
    end
endmodule : testbench
